// File: common/ctc_pkg.sv
// Shared constants and types of the charge termination controller.
// Assumes one system clock and an oscillator tick that is synchronous to it.
package ctc_pkg;

  // ==========================================================================
  // Timing figures, as given for the nominal timer setting
  // ==========================================================================
  // Nominal safety timer period in minutes.
  localparam int unsigned SAFETY_MIN = 80;
  // Oscillator frequency in Hz that gives the nominal period.
  localparam longint unsigned OSC_HZ = 64'd518400;
  // Safety timer period in seconds.
  localparam int unsigned SAFETY_S = SAFETY_MIN * 60;
  // Battery voltage sampling interval in seconds.
  localparam int unsigned VSAMPLE_S = 4;
  // Temperature sampling interval in seconds.
  localparam int unsigned TSAMPLE_S = 8;
  // Temperature slope observation interval in seconds.
  localparam int unsigned SLOPE_S = 56;
  // Safety timer in oscillator cycles; exceeds 32 bits' signed range.
  localparam longint unsigned SAFETY_OSC = OSC_HZ * SAFETY_S;
  // One timer unit is one voltage sampling interval.
  localparam int unsigned UNITS_SAFETY = SAFETY_S / VSAMPLE_S;
  // Oscillator cycles per timer unit.
  localparam int unsigned UNIT_OSC = int'(SAFETY_OSC / UNITS_SAFETY);
  // The initial timer is this fraction of the safety timer.
  localparam int unsigned INIT_DIV = 80;
  localparam int unsigned INIT_UNITS = UNITS_SAFETY / INIT_DIV;
  // Peak voltage timer as a percentage of the safety timer.
  localparam int unsigned PEAK_PCT = 6;
  localparam int unsigned PEAK_UNITS = UNITS_SAFETY * PEAK_PCT / 100;
  // Timer units between two temperature samples.
  localparam int unsigned TSAMPLE_UNITS = TSAMPLE_S / VSAMPLE_S;
  // Temperature sample intervals spanned by one slope observation.
  localparam int unsigned SLOPE_SAMPLES = SLOPE_S / TSAMPLE_S;
  // The slope threshold input is compared against this multiple of the drop.
  localparam int unsigned SLOPE_MUL = 30;
  // A 0.25 percent drop below the peak is one part in this many.
  localparam int unsigned DROP_DEN = 400;
  // Test mode shrinks every timer by this factor.
  localparam int unsigned TEST_DIV = 512;
  // Trickle period in oscillator cycles; the switch releases one of them.
  localparam int unsigned TRICKLE_PERIOD = 128;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned UNIT_W = 11;
  localparam int unsigned PEAK_W = 7;
  localparam int unsigned FILL_W = 3;
  localparam int unsigned TRK_W = 7;
  localparam int unsigned PRE_W = 32;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Charge phases.
  typedef enum logic [1:0] {
    ctc_check,
    ctc_fast,
    ctc_trickle,
    ctc_suspend
  } ctc_phase_t;

  // Comparator flags from the analog front end, each high when true.
  typedef struct packed {
    logic vbt_low_init;  // Battery below the early lower limit.
    logic vbt_low_run;   // Battery below the raised lower limit.
    logic vbt_high;      // Battery above the upper limit.
    logic vbt_max;       // Battery above the maximum-voltage cutoff.
    logic temp_hot;      // Temperature sense reports too hot.
    logic temp_cold;     // Temperature sense reports too cold.
    logic slope_off;     // Slope threshold input near supply.
    logic mode_gnd;      // Mode input tied to ground.
    logic mode_vcc;      // Mode input tied to supply.
  } ctc_cmp_t;

  // Cause of the end of fast charge.
  typedef struct packed {
    logic dv;      // Negative voltage step.
    logic zero_dv; // Peak voltage timer.
    logic slope;   // Temperature slope.
    logic safety;  // Safety timer.
    logic vmax;    // Maximum voltage.
  } ctc_cause_t;

endpackage

// File: logic/ctc_ctrl.sv
// Control unit of a NiMH/NiCd fast-charge controller.
// Assumes digitised sense codes synchronous to clk, an oscillator tick pulse
// and asynchronous comparator flags from the analog front end.
`timescale 1ns/1ps
module ctc_ctrl #(
  parameter int unsigned ADC_W = 12,
  parameter int unsigned UNIT_CYCLES = ctc_pkg::UNIT_OSC
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Oscillator tick, one cycle per oscillator period.
  input wire logic osc_tick,
  // Asynchronous comparator flags.
  input wire ctc_pkg::ctc_cmp_t cmp_async,
  // Digitised sense codes.
  input wire logic [ADC_W-1:0] battery_voltage_sense,
  input wire logic [ADC_W-1:0] battery_temp_sense,
  input wire logic [ADC_W-1:0] slope_threshold_input,
  // Open-drain current switch; high enable pulls the pin low.
  output logic charge_current_switch_o,
  output logic charge_current_switch_oe,
  // Status.
  output ctc_pkg::ctc_phase_t phase,
  output logic init_elapsed,
  output logic hot_latched,
  output ctc_pkg::ctc_cause_t term_cause
);

  // ==========================================================================
  // State
  // ==========================================================================
  localparam int unsigned DV_W = ADC_W + 9;
  localparam int unsigned SL_W = ADC_W + 5;

  typedef struct packed {
    ctc_pkg::ctc_phase_t phase;
    logic [ctc_pkg::UNIT_W-1:0] units;      // Elapsed timer units.
    logic init_done;                        // Initial timer has elapsed.
    logic [ADC_W-1:0] peak;                 // Highest voltage sample.
    logic [ctc_pkg::PEAK_W-1:0] peak_units; // Units since the peak rose.
    logic tphase;                           // Unit parity for temp sampling.
    logic [ctc_pkg::FILL_W-1:0] fill;       // Temperature samples held.
    logic [ctc_pkg::SLOPE_SAMPLES-1:0][ADC_W-1:0] hist;
    logic hot;                              // Over-temperature latch.
    logic [ctc_pkg::TRK_W-1:0] trk;         // Trickle position.
    logic sw_on;                            // Switch conducting.
    ctc_pkg::ctc_cause_t cause;
  } ctc_ctrl_state_t;

  ctc_ctrl_state_t st;
  ctc_ctrl_state_t next_st;

  // Synchronised comparator flags.
  ctc_pkg::ctc_cmp_t cmp;
  // Timer-unit pulse.
  logic unit_tick;
  // Decoded mode.
  logic test_mode;
  logic reduced_termination_mode;
  // Fault and termination terms.
  logic volt_fault;
  logic temp_fault;
  logic [DV_W-1:0] dv_scaled;
  logic [SL_W-1:0] sl_scaled;
  ctc_pkg::ctc_cause_t hit;

  // ==========================================================================
  // Input synchroniser and timer prescaler
  // ==========================================================================
  // Comparator flags cross in through two stages first.
  ctc_sync #(
    .W($bits(ctc_pkg::ctc_cmp_t))
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .d(cmp_async),
    .q(cmp)
  );

  // Timer units count oscillator cycles, shortened in test mode.
  ctc_prescaler #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_pre (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .clear(st.phase != ctc_pkg::ctc_fast),
    .test_mode(test_mode),
    .osc_tick(osc_tick),
    .unit_tick(unit_tick)
  );

  // ==========================================================================
  // Mode decode and fault terms
  // ==========================================================================
  // Supply selects test mode; ground the reduced set; floating is normal.
  always_comb begin
    test_mode = cmp.mode_vcc;
    reduced_termination_mode = cmp.mode_gnd & ~cmp.mode_vcc;
  end

  // The lower voltage limit rises once the initial timer is done.
  always_comb begin
    if (st.init_done) begin
      volt_fault = cmp.vbt_low_run | cmp.vbt_high;
    end else begin
      volt_fault = cmp.vbt_low_init | cmp.vbt_high;
    end
    temp_fault = cmp.temp_hot | cmp.temp_cold;
  end

  // ==========================================================================
  // Termination arithmetic
  // ==========================================================================
  // A drop is flagged when it exceeds one four-hundredth of the peak; the
  // comparison is done by multiplication to avoid a divider.
  always_comb begin
    dv_scaled = '0;
    if (st.peak > battery_voltage_sense) begin
      dv_scaled = DV_W'(st.peak - battery_voltage_sense) *
                  DV_W'(ctc_pkg::DROP_DEN);
    end
    sl_scaled = '0;
    if (st.hist[ctc_pkg::SLOPE_SAMPLES-1] > battery_temp_sense) begin
      sl_scaled = SL_W'(st.hist[ctc_pkg::SLOPE_SAMPLES-1] -
                        battery_temp_sense) *
                  SL_W'(ctc_pkg::SLOPE_MUL);
    end
  end

  // Termination candidates, judged on the unit tick; the maximum-voltage check is judged every cycle.
  always_comb begin
    hit = '0;
    if (unit_tick) begin
      hit.dv = st.init_done & ~reduced_termination_mode &
               (dv_scaled > DV_W'(st.peak));
      hit.zero_dv = st.init_done & (battery_voltage_sense <= st.peak) &
                    (st.peak_units >=
                     ctc_pkg::PEAK_W'(ctc_pkg::PEAK_UNITS - 1));
      // The slope spans seven sample intervals, 56 s at 80 min.
      hit.slope = st.init_done & ~cmp.slope_off & st.tphase &
                  (st.fill == ctc_pkg::FILL_W'(ctc_pkg::SLOPE_SAMPLES)) &
                  (sl_scaled > SL_W'(slope_threshold_input));
      hit.safety = st.units >=
                   ctc_pkg::UNIT_W'(ctc_pkg::UNITS_SAFETY - 1);
    end
    hit.vmax = st.init_done & cmp.vbt_max;
  end

  // ==========================================================================
  // Charge sequencer
  // ==========================================================================
  // One pass per enabled cycle decides the phase and updates the timers.
  always_comb begin
    next_st = st;
    if (ce) begin
      // Over-temperature is remembered whenever it is seen outside trickle.
      if (cmp.temp_hot && st.phase != ctc_pkg::ctc_trickle) begin
        next_st.hot = 1'b1;
      end
      case (st.phase)
        ctc_pkg::ctc_check: begin
          next_st.sw_on = 1'b1;
          if (volt_fault || temp_fault) begin
            next_st.phase = ctc_pkg::ctc_suspend;
          end else begin
            // Fresh charge cycle: clear every timer and history.
            next_st.phase = ctc_pkg::ctc_fast;
            next_st.units = '0;
            next_st.init_done = 1'b0;
            next_st.peak = '0;
            next_st.peak_units = '0;
            next_st.tphase = 1'b0;
            next_st.fill = '0;
            next_st.hist = '0;
            next_st.sw_on = 1'b0;
          end
        end
        ctc_pkg::ctc_fast: begin
          if (volt_fault || temp_fault) begin
            // Faults inhibit current; all but over-temperature restart the sequence later.
            next_st.phase = ctc_pkg::ctc_suspend;
            next_st.sw_on = 1'b1;
          end else if (hit != '0) begin
            // Fast charge ends for good; trickle takes over.
            next_st.phase = ctc_pkg::ctc_trickle;
            next_st.cause = hit;
            next_st.trk = '0;
            next_st.sw_on = 1'b0;
          end else begin
            next_st.sw_on = 1'b0;
            if (unit_tick) begin
              next_st.units = st.units + 1'b1;
              if (st.units >= ctc_pkg::UNIT_W'(ctc_pkg::INIT_UNITS - 1)) begin
                next_st.init_done = 1'b1;
              end
              // Voltage is sampled once per unit.
              if (battery_voltage_sense > st.peak) begin
                next_st.peak = battery_voltage_sense;
                next_st.peak_units = '0;
              end else begin
                next_st.peak_units = st.peak_units + 1'b1;
              end
              // Temperature is sampled every second unit.
              next_st.tphase = ~st.tphase;
              if (st.tphase) begin
                next_st.hist = {st.hist[ctc_pkg::SLOPE_SAMPLES-2:0],
                                battery_temp_sense};
                if (st.fill != ctc_pkg::FILL_W'(ctc_pkg::SLOPE_SAMPLES)) begin
                  next_st.fill = st.fill + 1'b1;
                end
              end
            end
          end
        end
        ctc_pkg::ctc_trickle: begin
          // Release the switch for one oscillator cycle of 128.
          if (osc_tick) begin
            next_st.trk = st.trk + 1'b1;
          end
          next_st.sw_on = (st.trk != '0);
        end
        ctc_pkg::ctc_suspend: begin
          next_st.sw_on = 1'b1;
          next_st.init_done = 1'b0;
          // Cold and voltage faults clear by themselves; heat does not.
          if (!st.hot && !cmp.temp_hot && !cmp.temp_cold &&
              !cmp.vbt_low_init && !cmp.vbt_high) begin
            next_st.phase = ctc_pkg::ctc_check;
          end
        end
        default: begin
          next_st.phase = ctc_pkg::ctc_check;
          next_st.sw_on = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset is the power-on point: check phase with the switch conducting.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.phase <= ctc_pkg::ctc_check;
      st.sw_on <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The pin is only ever pulled low, so its data level is a constant zero
  // driven by a continuous assignment, not held in the state word.
  assign charge_current_switch_o = 1'b0;
  assign charge_current_switch_oe = st.sw_on;
  assign phase = st.phase;
  assign init_elapsed = st.init_done;
  assign hot_latched = st.hot;
  assign term_cause = st.cause;

endmodule

// File: logic/ctc_prescaler.sv
// Divides oscillator ticks down to one timer-unit pulse.
// Assumes osc_tick is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module ctc_prescaler #(
  parameter int unsigned UNIT_CYCLES = ctc_pkg::UNIT_OSC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Control.
  input wire logic clear,
  input wire logic test_mode,
  input wire logic osc_tick,
  // Result.
  output logic unit_tick
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [ctc_pkg::PRE_W-1:0] count;
    logic tick;
  } ctc_pre_state_t;

  ctc_pre_state_t st;
  ctc_pre_state_t next_st;
  // Terminal count; test mode shrinks it so all timers scale together.
  logic [ctc_pkg::PRE_W-1:0] last;

  always_comb begin
    if (test_mode) begin
      last = ctc_pkg::PRE_W'(UNIT_CYCLES / ctc_pkg::TEST_DIV - 1);
    end else begin
      last = ctc_pkg::PRE_W'(UNIT_CYCLES - 1);
    end
  end

  // Count oscillator ticks and emit one pulse per unit.
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.tick = 1'b0;
      if (clear) begin
        // Restarting aligns every timer with the start of a charge.
        next_st.count = '0;
      end else if (osc_tick) begin
        if (st.count >= last) begin
          next_st.count = '0;
          next_st.tick = 1'b1;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign unit_tick = st.tick;

endmodule

// File: logic/ctc_sync.sv
// Two-stage synchroniser for a group of level signals.
// Assumes the inputs are asynchronous levels; the clock enable freezes it.
`timescale 1ns/1ps
module ctc_sync #(
  parameter int unsigned W = 9
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================================
  // State
  // ==========================================================================
  // The first stage is read only by the second stage.
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ctc_sync_state_t;

  ctc_sync_state_t st;
  ctc_sync_state_t next_st;

  // Shift the inputs through both stages while enabled.
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.meta = d;
      next_st.stable = st.meta;
    end
  end

  // Register the state; reset to all zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;

endmodule

// File: sim/ctc_ctrl_asserts.sv
// Port-level assertions for the charge termination control unit.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module ctc_ctrl_asserts #(
  parameter int unsigned ADC_W = 12,
  parameter int unsigned UNIT_CYCLES = ctc_pkg::UNIT_OSC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Watched ports.
  input wire ctc_pkg::ctc_cmp_t cmp_async,
  input wire logic charge_current_switch_oe,
  input wire ctc_pkg::ctc_phase_t phase,
  input wire logic init_elapsed,
  input wire logic hot_latched,
  input wire ctc_pkg::ctc_cause_t term_cause
);
  // =====
  // Sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A hot flag arrives while fast charging.
  sequence s_hot;
    phase == ctc_pkg::ctc_fast && $rose(cmp_async.temp_hot);
  endsequence
  // A low battery is held after the early window has closed.
  sequence s_low_run;
    (phase == ctc_pkg::ctc_fast && init_elapsed &&
     cmp_async.vbt_low_run) [*3];
  endsequence
  // =====
  // Assertions
  AST_RST_ON: assert property ($rose(reset_n) |->
    charge_current_switch_oe && phase == ctc_pkg::ctc_check)
    else $error("switch not on after reset");
  AST_FAST_OFF: assert property (
    phase == ctc_pkg::ctc_fast |-> !charge_current_switch_oe)
    else $error("switch on during fast charge");
  AST_FAULT_ON: assert property (
    phase inside {ctc_pkg::ctc_check, ctc_pkg::ctc_suspend}
    |-> charge_current_switch_oe) else $error("switch off in fault");
  AST_TRK_STAY: assert property (
    phase == ctc_pkg::ctc_trickle |=> phase == ctc_pkg::ctc_trickle)
    else $error("trickle left");
  AST_TRK_CAUSE: assert property (
    $rose(phase == ctc_pkg::ctc_trickle) |-> term_cause != 5'h00)
    else $error("trickle without cause");
  AST_INIT_FIRST: assert property (
    phase == ctc_pkg::ctc_fast && !init_elapsed |=>
    phase != ctc_pkg::ctc_trickle) else $error("early termination");
  AST_HOT_HOLD: assert property (hot_latched |=> hot_latched)
    else $error("hot latch dropped");
  AST_HOT_SUSP: assert property (
    hot_latched && phase != ctc_pkg::ctc_trickle |=>
    phase == ctc_pkg::ctc_suspend) else $error("hot latch not held");
  AST_SYNC: assert property (s_hot |=> phase == ctc_pkg::ctc_fast)
    else $error("flag acted on unsynchronised");
  AST_HOT: assert property (
    s_hot |-> ##[2:5] phase == ctc_pkg::ctc_suspend)
    else $error("hot flag did not suspend");
  AST_RUN_LIMIT: assert property (
    s_low_run |-> ##[0:3] phase != ctc_pkg::ctc_fast)
    else $error("low battery kept charging");
  AST_AC: assert property (
    $rose(term_cause.dv) |-> !$past(cmp_async.mode_gnd, 3))
    else $error("step end with mode at ground");
endmodule

bind ctc_ctrl ctc_ctrl_asserts #(.ADC_W(ADC_W),
  .UNIT_CYCLES(UNIT_CYCLES)) u_ast (.clk(clk), .reset_n(reset_n),
  .cmp_async(cmp_async),
  .charge_current_switch_oe(charge_current_switch_oe),
  .phase(phase), .init_elapsed(init_elapsed),
  .hot_latched(hot_latched), .term_cause(term_cause));

// File: sim/ctc_ctrl_tb_top.sv
// Self-checking bench of the charge termination control unit.
// Assumes the front end model and a bound checker.
`timescale 1ns/1ps
module ctc_ctrl_tb_top;
  // =====
  // Signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hot = 1'b0;
  logic cold = 1'b0;
  logic ramp = 1'b0;
  logic [1:0] mode = 2'd0;
  logic [11:0] mv = 12'h4b0;
  logic [11:0] temp = 12'h800;
  logic [11:0] thr = 12'hfff;
  logic osc_tick, sw_o, sw_oe, init_el, hot_l;
  ctc_pkg::ctc_cmp_t cmp;
  ctc_pkg::ctc_phase_t phase;
  ctc_pkg::ctc_cause_t cause;
  int fail_count = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  // The temperature code falls one step per oscillator tick when ramping.
  always @(negedge clk) if (ramp && osc_tick) temp <= temp - 12'h001;
  ctc_front_model u_fe (.clk(clk), .mv(mv), .hot(hot), .cold(cold),
    .mode(mode), .osc_tick(osc_tick), .cmp(cmp));
  // A short unit keeps the long timers within the run.
  ctc_ctrl #(.ADC_W(12), .UNIT_CYCLES(512)) uut (.clk(clk),
    .reset_n(reset_n), .ce(1'b1), .osc_tick(osc_tick), .cmp_async(cmp),
    .battery_voltage_sense(mv), .battery_temp_sense(temp),
    .slope_threshold_input(thr), .charge_current_switch_o(sw_o),
    .charge_current_switch_oe(sw_oe), .phase(phase),
    .init_elapsed(init_el), .hot_latched(hot_l), .term_cause(cause));
  // =====
  // Helpers
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(int n);
    repeat (n) @(negedge clk);
  endtask
  // Flags are set before release so they are valid once synchronised.
  task automatic rst(logic [1:0] m, logic [11:0] v);
    reset_n = 1'b0;
    mode = m;
    mv = v;
    hot = 1'b0;
    cold = 1'b0;
    run(3);
    reset_n = 1'b1;
    run(6);
  endtask
  task automatic wait_ph(ctc_pkg::ctc_phase_t p, int n);
    for (int i = 0; i < n && phase !== p; i++) @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // =====
  // Scenarios
  task automatic t_timer();
    int n;
    n = 0;
    rst(2'd2, 12'h4b0);
    chk(phase, ctc_pkg::ctc_fast);
    chk({sw_oe, sw_o}, 2'b00);
    run(20);
    chk(init_el, 1'b0);
    run(20);
    chk(init_el, 1'b1);
    run(60);
    chk(phase, ctc_pkg::ctc_fast);
    wait_ph(ctc_pkg::ctc_trickle, 300);
    chk(cause, 5'b01000);
    for (int i = 0; i < 1024; i++) begin
      run(1);
      if (sw_oe === 1'b0) n++;
    end
    chk(n, 8);
    hot = 1'b1;
    mv = 12'hbb8;
    run(10);
    chk(phase, ctc_pkg::ctc_trickle);
    $display("timer test done");
  endtask
  task automatic t_dv(logic [1:0] m, ctc_pkg::ctc_phase_t p,
                      logic [4:0] c);
    rst(m, 12'h7d0);
    run(15000);
    chk(init_el, 1'b0);
    run(1200);
    chk(init_el, 1'b1);
    mv = 12'h7cb;
    run(2500);
    chk(phase, ctc_pkg::ctc_fast);
    mv = 12'h7c6;
    run(2500);
    chk(phase, p);
    chk(cause, c);
    $display("step test done");
  endtask
  task automatic t_window();
    rst(2'd2, 12'h190);
    chk(phase, ctc_pkg::ctc_fast);
    wait_ph(ctc_pkg::ctc_suspend, 100);
    chk({phase, init_el}, {ctc_pkg::ctc_suspend, 1'b1});
    mv = 12'h3e8;
    wait_ph(ctc_pkg::ctc_fast, 20);
    chk(phase, ctc_pkg::ctc_fast);
    mv = 12'h064;
    run(6);
    chk(phase, ctc_pkg::ctc_suspend);
    rst(2'd2, 12'hbb8);
    run(4);
    chk(phase, ctc_pkg::ctc_suspend);
    $display("window test done");
  endtask
  task automatic t_temp();
    rst(2'd0, 12'h3e8);
    cold = 1'b1;
    run(6);
    chk({phase, hot_l, sw_oe}, {ctc_pkg::ctc_suspend, 2'b01});
    cold = 1'b0;
    run(8);
    chk(phase, ctc_pkg::ctc_fast);
    hot = 1'b1;
    run(8);
    chk({phase, hot_l}, {ctc_pkg::ctc_suspend, 1'b1});
    hot = 1'b0;
    run(20);
    chk({phase, hot_l}, {ctc_pkg::ctc_suspend, 1'b1});
    $display("temperature test done");
  endtask
  task automatic t_slope(logic [11:0] t, logic [4:0] c);
    rst(2'd2, 12'h3e8);
    thr = t;
    ramp = 1'b1;
    wait_ph(ctc_pkg::ctc_trickle, 400);
    ramp = 1'b0;
    chk(cause, c);
    temp = 12'h800;
    $display("slope test done");
  endtask
  // =====
  // Main sequence and watchdog
  initial begin
    run(1);
    chk(sw_oe, 1'b1);
    chk(phase, ctc_pkg::ctc_check);
    chk({init_el, hot_l, cause}, 7'h00);
    t_timer();
    t_dv(2'd0, ctc_pkg::ctc_trickle, 5'b10000);
    t_dv(2'd1, ctc_pkg::ctc_fast, 5'b00000);
    t_window();
    t_temp();
    t_slope(12'h12c, 5'b00100);
    t_slope(12'h258, 5'b01000);
    report_and_stop();
  end
  // The tests need about 220 us; this cuts a hang well after that while
  // keeping the whole run under 100,000 clock cycles.
  initial begin
    #400us;
    fail_count++;
    report_and_stop();
  end
endmodule

// File: sim/ctc_front_model.sv
// Model of the analog front end: comparators and the oscillator.
// Assumes battery levels in millivolts and a bench that sets conditions.
`timescale 1ns/1ps
module ctc_front_model #(
  parameter logic [11:0] VMAX_MV = 12'ha5a
) (
  // Clock.
  input wire logic clk,
  // Conditions set by the bench.
  input wire logic [11:0] mv,
  input wire logic hot,
  input wire logic cold,
  input wire logic [1:0] mode,
  // Oscillator and flags.
  output logic osc_tick,
  output ctc_pkg::ctc_cmp_t cmp
);
  // =====
  // Oscillator
  initial osc_tick = 1'b0;
  // It runs free at half the clock rate, so a tick lasts one cycle.
  always @(negedge clk) osc_tick <= ~osc_tick;
  // =====
  // Comparators; the slope disable input is never near supply here.
  always_comb begin
    cmp.vbt_low_init = mv < 12'h0a0;
    cmp.vbt_low_run = mv < 12'h2b2;
    cmp.vbt_high = mv > 12'ha8c;
    cmp.vbt_max = mv > VMAX_MV;
    cmp.temp_hot = hot;
    cmp.temp_cold = cold;
    cmp.slope_off = 1'b0;
    cmp.mode_gnd = mode == 2'd1;
    cmp.mode_vcc = mode == 2'd2;
  end
endmodule
